// >>> design/ifc_ctrl_regs.sv
// Purpose: interface-control register, its write-1-to-set alias and the logic it steers
// Assumes: register commands arrive as one-cycle strobes once the link command has completed
// Notes: mode exit events come from the serial/uart engines as one-cycle pulses
//
// Contract
// - invert bit complements external vbus flag
// - external vbus flag comes from fault pin
// - resume enable lets device send resume itself
// - clock power bit affects clock only, serial/uart
// - serial/uart modes: clock powered when bit set
// - clock power bit ignored while low power
// - uart select switches pins to uart
// - leaving uart mode clears uart select
// - three-wire select uses 3-pin serial interface
// - six-wire select uses 6-pin serial interface
// - leaving serial mode clears active select
// - set alias: ones set bits, no storage
// - set alias reads back control register
`timescale 1ns/1ps
`default_nettype none

module ifc_ctrl_regs (
	input wire logic clk,
	input wire logic rst_n,
	// register command from the link side
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// external vbus indicator
	input wire logic fault_pin,
	input wire logic vbus_valid_in,
	output logic vbus_flag_out,
	// resume and power
	input wire logic resume_event_in,
	input wire logic low_power_n,
	output logic auto_resume_tx,
	output logic clock_power_en,
	// mode control
	input wire logic uart_exit_in,
	input wire logic serial_exit_in,
	output ifc_ctrl_pkg::link_mode_t link_mode,
	output logic protect_disable,
	output logic [7:0] control_value
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ifc_ctrl_pkg::interface_control_t ctrl;
		logic [7:0] rdata;
		logic rvalid;
	} state_t;

	state_t state_reg;
	state_t state_next;
	ifc_ctrl_pkg::reg_cmd_t cmd;
	logic ext_vbus_flag_in;
	logic vbus_flag_comp;

	// uart wins over serial if the link sets several selects at once
	function automatic ifc_ctrl_pkg::link_mode_t decode_mode(
		input ifc_ctrl_pkg::interface_control_t c
	);
		if (c.uart_mode_select)
			decode_mode = ifc_ctrl_pkg::mode_uart;
		else if (c.six_wire_serial_select)
			decode_mode = ifc_ctrl_pkg::mode_six_wire;
		else if (c.three_wire_serial_select)
			decode_mode = ifc_ctrl_pkg::mode_three_wire;
		else
			decode_mode = ifc_ctrl_pkg::mode_parallel;
	endfunction : decode_mode

	function automatic logic hits_control(input logic [5:0] a);
		hits_control = (a == ifc_ctrl_pkg::interface_control_addr) ||
			(a == ifc_ctrl_pkg::interface_control_set_alias_addr);
	endfunction : hits_control

	assign cmd = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		// mode engines drop their select when the mode ends
		if (uart_exit_in)
		begin
			state_next.ctrl.uart_mode_select = 1'b0;
		end
		if (serial_exit_in)
		begin
			state_next.ctrl.three_wire_serial_select = 1'b0;
			state_next.ctrl.six_wire_serial_select = 1'b0;
		end
		// a completed write is the newer command, so it overrides an exit in the same cycle
		if (cmd.write)
		begin
			if (cmd.addr == ifc_ctrl_pkg::interface_control_addr)
			begin
				state_next.ctrl = cmd.wdata;
			end
			else if (cmd.addr == ifc_ctrl_pkg::interface_control_set_alias_addr)
			begin
				state_next.ctrl = state_reg.ctrl | cmd.wdata;
			end
		end
		if (cmd.read)
		begin
			state_next.rvalid = 1'b1;
			if (hits_control(cmd.addr))
				state_next.rdata = state_reg.ctrl;
			else
				state_next.rdata = ifc_ctrl_pkg::unmapped_read_value;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg.ctrl <= ifc_ctrl_pkg::interface_control_reset;
			state_reg.rdata <= 8'h00;
			state_reg.rvalid <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata = state_reg.rdata;
	assign reg_rvalid = state_reg.rvalid;
	assign control_value = state_reg.ctrl;
	assign protect_disable = state_reg.ctrl.protect_disable;

	assign ext_vbus_flag_in = fault_pin;
	assign vbus_flag_comp = ext_vbus_flag_in ^ state_reg.ctrl.vbus_flag_invert;
	assign vbus_flag_out = state_reg.ctrl.vbus_flag_unqualified ?
		vbus_flag_comp : (vbus_flag_comp & vbus_valid_in);

	// without the enable the link must drive resume itself
	assign auto_resume_tx = state_reg.ctrl.resume_self_signal_en & resume_event_in;

	// uart, three-wire and six-wire pin usage
	assign link_mode = decode_mode(state_reg.ctrl);

	// only the clock tree is gated here; analog and register blocks keep running
	always_comb
	begin
		if (!low_power_n)
			clock_power_en = 1'b0;
		else if (decode_mode(state_reg.ctrl) == ifc_ctrl_pkg::mode_parallel)
			clock_power_en = 1'b1;
		else
			clock_power_en = state_reg.ctrl.serial_clock_power_n;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence alias_read_s;
		reg_read && !reg_write && hits_control(reg_addr);
	endsequence

	sequence alias_answer_s;
		reg_rvalid && reg_rdata == $past(control_value);
	endsequence

	sequence set_write_s;
		reg_write && reg_addr == ifc_ctrl_pkg::interface_control_set_alias_addr;
	endsequence

	flag_invert_a: assert property (vbus_flag_out ==
		(control_value[ifc_ctrl_pkg::vbus_flag_unqualified_bit] ?
		(fault_pin ^ control_value[ifc_ctrl_pkg::vbus_flag_invert_bit]) :
		((fault_pin ^ control_value[ifc_ctrl_pkg::vbus_flag_invert_bit]) & vbus_valid_in)))
		else $error("vbus flag does not follow invert setting");

	resume_gate_a: assert property (auto_resume_tx |->
		control_value[ifc_ctrl_pkg::resume_self_signal_en_bit] && resume_event_in)
		else $error("resume sent without enable");

	clock_parallel_a: assert property ((low_power_n &&
		link_mode == ifc_ctrl_pkg::mode_parallel) |-> clock_power_en)
		else $error("clock gated in parallel mode");

	clock_serial_a: assert property ((low_power_n &&
		link_mode != ifc_ctrl_pkg::mode_parallel) |->
		clock_power_en == control_value[ifc_ctrl_pkg::serial_clock_power_n_bit])
		else $error("serial clock power wrong");

	clock_suspend_a: assert property (!low_power_n |-> !clock_power_en)
		else $error("clock powered while in low power");

	uart_exit_a: assert property ((uart_exit_in && !reg_write) |=>
		!control_value[ifc_ctrl_pkg::uart_mode_select_bit])
		else $error("uart select not cleared on exit");

	serial_exit_a: assert property ((serial_exit_in && !reg_write) |=>
		!control_value[ifc_ctrl_pkg::three_wire_serial_select_bit] &&
		!control_value[ifc_ctrl_pkg::six_wire_serial_select_bit])
		else $error("serial select not cleared on exit");

	set_alias_a: assert property (set_write_s |=>
		control_value == ($past(control_value) | $past(reg_wdata)))
		else $error("set alias did not or in data");

	alias_read_a: assert property (alias_read_s |=> alias_answer_s)
		else $error("alias read differs from control register");

	write_apply_a: assert property ((reg_write &&
		reg_addr == ifc_ctrl_pkg::interface_control_addr) |=> control_value == $past(reg_wdata))
		else $error("control write not applied");

	// ----------------------------------------------------------------
	// mode decode checks
	// ----------------------------------------------------------------
	// the priority order matters only if the link sets several selects at once

	uart_mode_a: assert property (control_value[ifc_ctrl_pkg::uart_mode_select_bit] |->
		link_mode == ifc_ctrl_pkg::mode_uart)
		else $error("uart select does not give uart mode");

	six_mode_a: assert property ((!control_value[ifc_ctrl_pkg::uart_mode_select_bit] &&
		control_value[ifc_ctrl_pkg::six_wire_serial_select_bit]) |->
		link_mode == ifc_ctrl_pkg::mode_six_wire)
		else $error("six-wire select does not give six-wire mode");

	three_mode_a: assert property ((!control_value[ifc_ctrl_pkg::uart_mode_select_bit] &&
		!control_value[ifc_ctrl_pkg::six_wire_serial_select_bit] &&
		control_value[ifc_ctrl_pkg::three_wire_serial_select_bit]) |->
		link_mode == ifc_ctrl_pkg::mode_three_wire)
		else $error("three-wire select does not give three-wire mode");

	parallel_mode_a: assert property ((control_value[2:0] == 3'h0) |->
		link_mode == ifc_ctrl_pkg::mode_parallel)
		else $error("no select set but link not parallel");

	// ----------------------------------------------------------------
	// output and bus checks
	// ----------------------------------------------------------------

	protect_out_a: assert property (protect_disable ==
		control_value[ifc_ctrl_pkg::protect_disable_bit])
		else $error("protect disable output differs from register");

	resume_fire_a: assert property ((control_value[ifc_ctrl_pkg::resume_self_signal_en_bit] &&
		resume_event_in) |-> auto_resume_tx)
		else $error("resume not sent although enabled");

	read_answer_a: assert property (reg_read |=> reg_rvalid)
		else $error("read command got no answer");

	rvalid_pulse_a: assert property (!reg_read |=> !reg_rvalid)
		else $error("read answer without read command");

	// read data must stand until the next read so a slow link can still pick it up
	rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	unmapped_read_a: assert property ((reg_read && !hits_control(reg_addr)) |=>
		reg_rdata == ifc_ctrl_pkg::unmapped_read_value)
		else $error("unmapped read returned nonzero data");

	unmapped_write_a: assert property ((reg_write && !hits_control(reg_addr) &&
		!uart_exit_in && !serial_exit_in) |=> $stable(control_value))
		else $error("write to other address changed register");

	// write and exit in one cycle: the write is the newer command and wins
	write_wins_a: assert property ((reg_write && uart_exit_in &&
		reg_addr == ifc_ctrl_pkg::interface_control_addr) |=> control_value == $past(reg_wdata))
		else $error("exit overrode a write in the same cycle");

endmodule : ifc_ctrl_regs

`default_nettype wire

// >>> pkg/ifc_ctrl_pkg.sv
// Purpose: constants and types for the interface-control register bank
// Assumes: 8-bit register data and 6-bit register addresses, as on the link register access
// Notes: bit positions follow the register layout; bit 7 drives protect_disable, bit 6 set skips the vbus_valid_in qualification of the vbus flag
package ifc_ctrl_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [5:0] interface_control_addr = 6'h07;
	localparam logic [5:0] interface_control_set_alias_addr = 6'h08;
	localparam logic [7:0] interface_control_reset = 8'h00;
	localparam logic [7:0] unmapped_read_value = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int protect_disable_bit = 7;
	localparam int vbus_flag_unqualified_bit = 6;
	localparam int vbus_flag_invert_bit = 5;
	localparam int resume_self_signal_en_bit = 4;
	localparam int serial_clock_power_n_bit = 3;
	localparam int uart_mode_select_bit = 2;
	localparam int three_wire_serial_select_bit = 1;
	localparam int six_wire_serial_select_bit = 0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic protect_disable;
		logic vbus_flag_unqualified;
		logic vbus_flag_invert;
		logic resume_self_signal_en;
		logic serial_clock_power_n;
		logic uart_mode_select;
		logic three_wire_serial_select;
		logic six_wire_serial_select;
	} interface_control_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [5:0] addr;
		logic [7:0] wdata;
	} reg_cmd_t;

	typedef enum logic [1:0] {
		mode_parallel,
		mode_uart,
		mode_three_wire,
		mode_six_wire
	} link_mode_t;

endpackage : ifc_ctrl_pkg

// >>> test/link_model.sv
// Purpose: link-side partner issuing register commands
// Assumes: one-cycle command strobes, answer one cycle after a read
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module link_model (
	// clock
	input wire logic clk,
	// register command
	output logic reg_write,
	output logic reg_read,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	// answer
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial
	begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 6'h3f;
		reg_wdata = 8'hff;
	end
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		ok = 1'b0;
		d = 8'h00;
		// bounded: a lost answer returns ok low
		for (int i = 0; i < 4 && !ok; i++)
		begin
			#1;
			if (reg_rvalid === 1'b1)
			begin
				ok = 1'b1;
				d = reg_rdata;
			end
			else
				@(posedge clk);
		end
	endtask : rd
endmodule : link_model
`default_nettype wire

// >>> test/tb_ulpi_interface_control_regs.sv
// Purpose: self-checking bench for the interface-control register bank
// Assumes: link_model issues commands; side inputs driven here
// Notes: combinational outputs are sampled 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module tb_ulpi_interface_control_regs;
	localparam logic [5:0] ctl_a = ifc_ctrl_pkg::interface_control_addr;
	localparam logic [5:0] set_a = ifc_ctrl_pkg::interface_control_set_alias_addr;
	logic clk = 1'b0;
	logic rst_n, reg_write, reg_read, reg_rvalid, fault_pin, vbus_valid_in, vbus_flag_out;
	logic resume_event_in, low_power_n, auto_resume_tx, clock_power_en, uart_exit_in;
	logic serial_exit_in, protect_disable;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, control_value;
	ifc_ctrl_pkg::link_mode_t link_mode;
	int mismatches = 0;
	int checked = 0;
	always #10 clk = ~clk;
	ifc_ctrl_regs ifc_ctrl_regs_inst (.clk(clk), .rst_n(rst_n), .reg_write(reg_write),
		.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_pin(fault_pin),
		.vbus_valid_in(vbus_valid_in), .vbus_flag_out(vbus_flag_out),
		.resume_event_in(resume_event_in), .low_power_n(low_power_n),
		.auto_resume_tx(auto_resume_tx), .clock_power_en(clock_power_en),
		.uart_exit_in(uart_exit_in), .serial_exit_in(serial_exit_in), .link_mode(link_mode),
		.protect_disable(protect_disable), .control_value(control_value));
	link_model link_model_inst (.clk(clk), .reg_write(reg_write), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	task automatic give_verdict;
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		link_model_inst.rd(a, d, ok);
		chk("reg_rvalid", 8'h01, {7'h00, ok});
		if (!ok)
			give_verdict();
		chk("reg_rdata", e, d);
	endtask : rdchk
	task automatic exit_pulse(input logic u);
		@(posedge clk);
		uart_exit_in <= u;
		serial_exit_in <= !u;
		@(posedge clk);
		uart_exit_in <= 1'b0;
		serial_exit_in <= 1'b0;
		#1;
	endtask : exit_pulse
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		fault_pin = 1'b0;
		vbus_valid_in = 1'b1;
		resume_event_in = 1'b1;
		low_power_n = 1'b1;
		uart_exit_in = 1'b0;
		serial_exit_in = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("link_mode", 8'h00, {6'h00, link_mode});
		chk("auto_resume_tx", 8'h00, {7'h00, auto_resume_tx});
		rdchk(ctl_a, 8'h00);
		link_model_inst.wr(ctl_a, 8'h30);
		rdchk(ctl_a, 8'h30);
		chk("auto_resume_tx", 8'h01, {7'h00, auto_resume_tx});
		chk("vbus_flag_out", 8'h01, {7'h00, vbus_flag_out});
		@(posedge clk);
		fault_pin <= 1'b1;
		#1;
		chk("vbus_flag_out", 8'h00, {7'h00, vbus_flag_out});
		link_model_inst.wr(set_a, 8'h04);
		#1;
		chk("control_value", 8'h34, control_value);
		chk("link_mode", 8'h01, {6'h00, link_mode});
		chk("clock_power_en", 8'h00, {7'h00, clock_power_en});
		rdchk(set_a, 8'h34);
		link_model_inst.wr(set_a, 8'h08);
		#1;
		chk("clock_power_en", 8'h01, {7'h00, clock_power_en});
		@(posedge clk);
		low_power_n <= 1'b0;
		#1;
		chk("clock_power_en", 8'h00, {7'h00, clock_power_en});
		@(posedge clk);
		low_power_n <= 1'b1;
		exit_pulse(1'b1);
		chk("control_value", 8'h38, control_value);
		for (int i = 0; i < 2; i++)
		begin
			link_model_inst.wr(set_a, 8'h01 << i);
			#1;
			chk("link_mode", 8'h03 - 8'(i), {6'h00, link_mode});
			exit_pulse(1'b0);
			chk("control_value", 8'h38, control_value);
		end
		link_model_inst.wr(6'h0a, 8'hff);
		link_model_inst.wr(ctl_a, 8'h00);
		rdchk(6'h0a, 8'h00);
		chk("auto_resume_tx", 8'h00, {7'h00, auto_resume_tx});
		chk("clock_power_en", 8'h01, {7'h00, clock_power_en});
		@(posedge clk);
		vbus_valid_in <= 1'b0;
		#1;
		chk("vbus_flag_out", 8'h00, {7'h00, vbus_flag_out});
		link_model_inst.wr(set_a, 8'hc0);
		#1;
		chk("vbus_flag_out", 8'h01, {7'h00, vbus_flag_out});
		chk("protect_disable", 8'h01, {7'h00, protect_disable});
		rdchk(ctl_a, 8'hc0);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("control_value", 8'h00, control_value);
		chk("protect_disable", 8'h00, {7'h00, protect_disable});
		give_verdict();
	end
endmodule : tb_ulpi_interface_control_regs
`default_nettype wire
